//--- rtc_dev.sv
// Notes on behaviour
// - sign bit one removes, zero adds cycles
// - zero trim value gives no correction
// - each trim unit is two oscillator cycles
// - trim register is volatile, cleared at reset
// - trim applied when minute counter increments
// - square-wave enable drives selected waveform on pin
// - rate codes give 32768, 8, 4, 1 cycles
// - undivided oscillator output ignores trim
// - 1 Hz: one period in sixty altered
// - positive trim delays fast waveforms once per minute
// - large negative trim may distort fast waveforms
// - top rate bit: every 1 Hz period trimmed
// - waveform disabled while on backup supply
// - static level mode only on main supply
// - on backup only alarm mode stays active
// - switch to backup only when main is below both trip level and backup level
// - serial access refused while on backup
// - factory ID in 0x00-0x07, rest blank
// - 48-bit ID: bytes 0 and 1 read 0xFF
// - ID reads wrap within sixteen bytes
// - ID write needs write enable and unlock
// - host writes ID in groups of eight
`timescale 1ns/1ns
`default_nettype none
module rtc_dev
#(
	parameter logic [63:0] P_UID   = 64'h0123456789ABCDEF, // Arbitrary value
	parameter logic        P_UID48 = 1'b0
)
(
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_osc,
	input  wire logic i_main_above_trip,
	input  wire logic i_main_above_backup,
	input  wire logic i_alarm,
	rtc_spi_if.dev    spi,
	output var  logic o_mfp_oe_b,
	output var  logic o_on_backup,
	output var  logic o_minute
);
	import rtc_pkg::*;
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] osc_q;
	logic [2:0] sck_q;
	logic [1:0] cs_q;
	logic [1:0] mosi_q;
	logic [1:0] trip_q;
	logic [1:0] bk_q;
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			osc_q  <= 3'h0;
			sck_q  <= 3'h0;
			cs_q   <= 2'h3;
			mosi_q <= 2'h0;
			trip_q <= 2'h3;
			bk_q   <= 2'h3;
		end
		else if (i_ce)
		begin
			osc_q  <= {osc_q[1:0], i_osc};
			sck_q  <= {sck_q[1:0], spi.sck};
			cs_q   <= {cs_q[0], spi.cs_b};
			mosi_q <= {mosi_q[0], spi.mosi};
			trip_q <= {trip_q[0], i_main_above_trip};
			bk_q   <= {bk_q[0], i_main_above_backup};
		end
	end
	wire osc_tick = osc_q[1] & ~osc_q[2];
	wire sck_rise = sck_q[1] & ~sck_q[2];
	wire sck_fall = ~sck_q[1] & sck_q[2];
	wire cs_act   = ~cs_q[1];
	// Trip hysteresis is analog; the comparator levels arrive already settled
	// supply switchover
	wire backup   = ~trip_q[1] & ~bk_q[1];
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic       sign_q;
	logic [7:0] outctl_q;
	logic [7:0] trim_q;
	logic [7:0] id_q [ID_BYTES];
	wire  [8:0] trim2 = {trim_q, 1'b0};
	wire  [1:0] rate  = outctl_q[1:0];
	// ----------------------------------------------------------------
	// Timing chain
	// ----------------------------------------------------------------
	logic [14:0] pre_q;
	logic [5:0]  sec_q;
	logic [8:0]  stall_q;
	wire stalled = (stall_q != 9'h000);
	wire sec_wrap = osc_tick & ~stalled & (pre_q == SEC_LAST);
	wire min_inc  = sec_wrap & (sec_q == MIN_LAST);
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pre_q    <= 15'h0000;
			sec_q    <= 6'h00;
			stall_q  <= 9'h000;
			o_minute <= 1'b0;
		end
		else if (i_ce)
		begin
			o_minute <= min_inc;
			if (osc_tick && stalled)
				stall_q <= 9'(stall_q - 9'h001);
			else if (min_inc)
			begin
				sec_q <= 6'h00;
				pre_q   <= sign_q ? {6'h00, trim2} : 15'h0000;
				stall_q <= sign_q ? 9'h000 : trim2;
			end
			else if (osc_tick)
			begin
				pre_q <= 15'(pre_q + 15'h0001);
				if (sec_wrap)
					sec_q <= 6'(sec_q + 6'h01);
			end
		end
	end
	// ----------------------------------------------------------------
	// Waveform and output pin
	// ----------------------------------------------------------------
	logic trim_wave;
	rtc_trim_div u_div
	(
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_tick  (osc_tick),
		.i_sign  (sign_q),
		.i_trim  (trim_q),
		.o_wave  (trim_wave)
	);
	// 1 Hz tap shows the one altered second
	// skip larger than tap period distorts it
	wire chain_wave = (rate == 2'h0) ? pre_q[14] :
	                  (rate == 2'h1) ? pre_q[2]  :
	                  (rate == 2'h2) ? pre_q[1]  : osc_q[2];
	wire div_wave   = outctl_q[B_RATE_HIGH] ? trim_wave : chain_wave;
	wire drive_wave = outctl_q[B_SQUARE_WAVE_OUTPUT_ENABLE] & ~backup;
	wire drive_alm  = ~drive_wave & outctl_q[B_ALM_EN];
	wire drive_lvl  = ~drive_wave & ~outctl_q[B_ALM_EN] & ~backup;
	// Open drain: a high level is a released pin
	wire mfp_val = drive_wave ? div_wave :
	               drive_alm  ? ~i_alarm :
	               drive_lvl  ? outctl_q[B_OUT_LEVEL] : 1'b1;
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_mfp_oe_b  <= 1'b1;
			o_on_backup <= 1'b0;
		end
		else if (i_ce)
		begin
			o_mfp_oe_b  <= mfp_val;
			o_on_backup <= backup;
		end
	end
	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	rtc_dst_t   state_q;
	logic [7:0] cmd_q;
	logic [7:0] addr_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic       oe_b_q;
	logic       wel_q;
	logic       unl_q;
	logic       idw_q;
	logic [7:0] nx_q;
	logic       nx_v_q;
	wire [7:0] rx_byte   = {sh_q[6:0], mosi_q[1]};
	wire       byte_done = cs_act & sck_rise & (bit_q == 3'h7);
	wire       in_data   = byte_done & (state_q == DS_DATA);
	wire       is_idw    = (cmd_q == C_UNIQUE_ID_WRITE_COMMAND);
	wire       is_idr    = (cmd_q == C_UNIQUE_ID_READ_COMMAND);
	wire       is_rd     = (cmd_q == C_READ) | is_idr;
	// ID writes stay inside their group of eight
	wire [7:0] nxt_addr  = is_idw ? {addr_q[7:3], 3'(addr_q[2:0] + 3'h1)} : 8'(addr_q + 8'h01);
	wire [7:0] ld_addr   = (state_q == DS_ADDR) ? rx_byte : nxt_addr;
	wire [7:0] rd_reg    = (ld_addr == A_TKCTL)  ? {sign_q, 7'h00} :
	                       (ld_addr == A_OUTCTL) ? outctl_q :
	                       (ld_addr == A_TRIM)   ? trim_q : 8'h00;
	wire [7:0] rd_byte   = is_idr ? id_q[ld_addr[3:0]] : rd_reg;
	wire       reg_wr    = in_data & (cmd_q == C_WRITE);
	wire       id_wr     = in_data & is_idw;
	assign spi.miso      = tx_q[7];
	assign spi.miso_oe_b = oe_b_q;
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_q <= DS_CMD;
			cmd_q   <= 8'h00;
			addr_q  <= 8'h00;
			bit_q   <= 3'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			oe_b_q  <= 1'b1;
			wel_q   <= 1'b0;
			unl_q   <= 1'b0;
			idw_q   <= 1'b0;
			nx_q    <= 8'h00;
			nx_v_q  <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!cs_act)
			begin
				state_q <= DS_CMD;
				bit_q   <= 3'h0;
				oe_b_q  <= 1'b1;
				nx_v_q  <= 1'b0;
				if (idw_q)
				begin
					wel_q <= 1'b0;
					unl_q <= 1'b0;
					idw_q <= 1'b0;
				end
			end
			else
			begin
				if (sck_rise)
				begin
					bit_q <= 3'(bit_q + 3'h1);
					sh_q  <= rx_byte;
				end
				// First bit of a loaded byte must not shift away
				if (sck_fall && bit_q != 3'h0)
					tx_q <= {tx_q[6:0], 1'b0};
				// Next byte waits for the fall so the last bit stands while sck is high
				else if (sck_fall && nx_v_q)
				begin
					tx_q   <= nx_q;
					nx_v_q <= 1'b0;
				end
				if (byte_done)
				begin
					case (state_q)
						DS_CMD:
						begin
							cmd_q <= rx_byte;
							if (backup)
								state_q <= DS_SKIP;
							else if (rx_byte == C_WREN || rx_byte == C_WRDI)
							begin
								wel_q   <= (rx_byte == C_WREN);
								state_q <= DS_SKIP;
							end
							else if (rx_byte == C_UNLOCK)
								state_q <= DS_DATA;
							else if (rx_byte == C_UNIQUE_ID_WRITE_COMMAND)
								state_q <= (wel_q && unl_q) ? DS_ADDR : DS_SKIP;
							else if (rx_byte == C_READ || rx_byte == C_WRITE || rx_byte == C_UNIQUE_ID_READ_COMMAND)
								state_q <= DS_ADDR;
							else
								state_q <= DS_SKIP;
						end
						DS_ADDR:
						begin
							state_q <= DS_DATA;
							addr_q  <= rx_byte;
							if (is_rd)
							begin
								tx_q   <= rd_byte;
								oe_b_q <= 1'b0;
							end
						end
						DS_DATA:
						begin
							addr_q <= ld_addr;
							if (is_rd)
							begin
								nx_q   <= rd_byte;
								nx_v_q <= 1'b1;
							end
							if (cmd_q == C_UNLOCK)
								unl_q <= (rx_byte == UNLOCK_KEY);
							if (id_wr)
								idw_q <= 1'b1;
						end
						default:
							state_q <= DS_SKIP;
					endcase
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sign_q   <= SIGN_RST;
			outctl_q <= OUTCTL_RST;
			trim_q   <= TRIM_RST;
		end
		else if (i_ce && reg_wr)
		begin
			if (addr_q == A_TKCTL)
				sign_q <= rx_byte[B_TRIM_SIGN];
			if (addr_q == A_OUTCTL)
				outctl_q <= rx_byte;
			if (addr_q == A_TRIM)
				trim_q <= rx_byte;
		end
	end
	// ----------------------------------------------------------------
	// Unique ID store
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ID_BYTES; g++)
		begin : g_id
			localparam logic [7:0] INIT = (g >= ID_FACTORY) ? ID_BLANK :
				(P_UID48 && g < 2) ? ID_BLANK : P_UID[8*(7-g) +: 8];
			always_ff @(posedge i_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
					id_q[g] <= INIT;
				else if (i_ce && id_wr && addr_q[3:0] == 4'(g))
					id_q[g] <= rx_byte;
			end
		end
	endgenerate
endmodule
`default_nettype wire

//--- rtc_pkg.sv
`default_nettype none
package rtc_pkg;
	// ----------------------------------------------------------------
	// Device register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  A_TKCTL      = 8'h03;
	localparam logic [7:0]  A_OUTCTL     = 8'h07;
	localparam logic [7:0]  A_TRIM       = 8'h09;
	localparam int          B_TRIM_SIGN  = 7;
	localparam int          B_OUT_LEVEL  = 7;
	localparam int          B_SQUARE_WAVE_OUTPUT_ENABLE       = 6;
	localparam int          B_ALM_EN     = 4;
	localparam int          B_RATE_HIGH  = 2;
	localparam logic        SIGN_RST     = 1'b0;
	localparam logic [7:0]  OUTCTL_RST   = 8'h80;
	localparam logic [7:0]  TRIM_RST     = 8'h00;
	// ----------------------------------------------------------------
	// Serial commands
	// ----------------------------------------------------------------
	localparam logic [7:0]  C_READ       = 8'h13;
	localparam logic [7:0]  C_WRITE      = 8'h12;
	localparam logic [7:0]  C_WREN       = 8'h06;
	localparam logic [7:0]  C_WRDI       = 8'h04;
	localparam logic [7:0]  C_UNLOCK     = 8'h14;
	localparam logic [7:0]  C_UNIQUE_ID_READ_COMMAND     = 8'h33;
	localparam logic [7:0]  C_UNIQUE_ID_WRITE_COMMAND    = 8'h32;
	localparam logic [7:0]  UNLOCK_KEY   = 8'h55;
	// ----------------------------------------------------------------
	// Unique ID area
	// ----------------------------------------------------------------
	localparam int          ID_BYTES     = 16;
	localparam int          ID_FACTORY   = 8;
	localparam logic [3:0]  ID_GROUP     = 4'h8;
	localparam logic [7:0]  ID_BLANK     = 8'hFF;
	// ----------------------------------------------------------------
	// Timing chain
	// ----------------------------------------------------------------
	localparam logic [15:0] SEC_CYC      = 16'h8000;
	localparam logic [14:0] SEC_LAST     = 15'h7FFF;
	localparam logic [5:0]  MIN_LAST     = 6'h3B;
	// ----------------------------------------------------------------
	// Host controller registers and link timing
	// ----------------------------------------------------------------
	localparam logic [2:0]  HR_CMD       = 3'h0;
	localparam logic [2:0]  HR_ADDR      = 3'h1;
	localparam logic [2:0]  HR_LEN       = 3'h2;
	localparam logic [2:0]  HR_TXD       = 3'h3;
	localparam logic [2:0]  HR_STAT      = 3'h4;
	localparam logic [2:0]  HR_RXD       = 3'h5;
	localparam logic [3:0]  SCK_HALF     = 4'h8;
	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DS_CMD  = 2'b00,
		DS_ADDR = 2'b01,
		DS_DATA = 2'b11,
		DS_SKIP = 2'b10
	} rtc_dst_t;
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_LOAD  = 2'b01,
		HS_SHIFT = 2'b11,
		HS_END   = 2'b10
	} rtc_hst_t;
endpackage
`default_nettype wire

//--- rtc_spi_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtc_spi_if;
	logic sck;
	logic cs_b;
	logic mosi;
	logic miso;
	logic miso_oe_b;
	modport dev
	(
		input  sck,
		input  cs_b,
		input  mosi,
		output miso,
		output miso_oe_b
	);
	modport host
	(
		output sck,
		output cs_b,
		output mosi,
		input  miso,
		input  miso_oe_b
	);
endinterface
`default_nettype wire

//--- rtc_trim_div.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_trim_div
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_ce,
	input  wire logic       i_tick,
	input  wire logic       i_sign,
	input  wire logic [7:0] i_trim,
	output var  logic       o_wave
);
	import rtc_pkg::*;
	logic [15:0] cnt_q;
	wire  [15:0] trim2 = {7'h00, i_trim, 1'b0};
	wire  [15:0] period = i_sign ? 16'(SEC_CYC - trim2) : 16'(SEC_CYC + trim2);
	wire         last   = (cnt_q == 16'(period - 16'h0001));
	wire  [15:0] cnt_d  = last ? 16'h0000 : 16'(cnt_q + 16'h0001);
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q  <= 16'h0000;
			o_wave <= 1'b0;
		end
		else if (i_ce && i_tick)
		begin
			cnt_q  <= cnt_d;
			o_wave <= (cnt_d < {1'b0, period[15:1]});
		end
	end
endmodule
`default_nettype wire

//--- rtc_host.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_host
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_ce,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output var  logic [7:0] o_rdata,
	rtc_spi_if.host         spi
);
	import rtc_pkg::*;
	// ----------------------------------------------------------------
	// Command registers
	// ----------------------------------------------------------------
	rtc_hst_t   st_q;
	logic [7:0] cmd_q;
	logic [7:0] adr_q;
	logic [3:0] len_q;
	logic [3:0] left_q;
	logic [7:0] txd_q;
	logic       txf_q;
	logic [7:0] rxd_q;
	logic       rxf_q;
	logic [1:0] ph_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [2:0] bc_q;
	logic [3:0] div_q;
	logic       sck_q;
	logic       cs_b_q;
	logic [1:0] miso_q;
	wire busy     = (st_q != HS_IDLE);
	wire go       = i_wr & (i_addr == HR_CMD) & ~busy;
	wire has_addr = (cmd_q == C_READ) | (cmd_q == C_WRITE) |
	                (cmd_q == C_UNIQUE_ID_READ_COMMAND) | (cmd_q == C_UNIQUE_ID_WRITE_COMMAND);
	wire rd_cmd   = (cmd_q == C_READ) | (cmd_q == C_UNIQUE_ID_READ_COMMAND);
	wire is_id    = (cmd_q == C_UNIQUE_ID_READ_COMMAND) | (cmd_q == C_UNIQUE_ID_WRITE_COMMAND);
	wire [3:0] len_go = (i_wdata == C_UNIQUE_ID_WRITE_COMMAND && len_q > ID_GROUP) ? ID_GROUP : len_q;
	wire [7:0] adr_out = is_id ? {4'h0, adr_q[3:0]} : adr_q;
	// Data phase stalls until software supplies or drains a byte
	wire data_ok  = rd_cmd ? ~rxf_q : txf_q;
	wire take_tx  = (st_q == HS_LOAD) & (ph_q == 2'h2) & ~rd_cmd & txf_q;
	wire half     = (div_q == 4'(SCK_HALF - 4'h1));
	wire byte_end = (st_q == HS_SHIFT) & half & sck_q & (bc_q == 3'h7);
	wire rx_set   = byte_end & (ph_q == 2'h2) & rd_cmd;
	wire [7:0] rx_byte = {rx_q[6:0], miso_q[1]};
	wire [7:0] rdmux = (i_addr == HR_CMD)  ? cmd_q :
	                   (i_addr == HR_ADDR) ? adr_q :
	                   (i_addr == HR_LEN)  ? {4'h0, len_q} :
	                   (i_addr == HR_TXD)  ? txd_q :
	                   (i_addr == HR_STAT) ? {5'h00, txf_q, rxf_q, busy} :
	                   (i_addr == HR_RXD)  ? rxd_q : 8'h00;
	assign spi.sck  = sck_q;
	assign spi.cs_b = cs_b_q;
	assign spi.mosi = sh_q[7];
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rdata <= 8'h00;
			adr_q   <= 8'h00;
			len_q   <= 4'h0;
			txd_q   <= 8'h00;
			txf_q   <= 1'b0;
			rxd_q   <= 8'h00;
			rxf_q   <= 1'b0;
			miso_q  <= 2'h0;
		end
		else if (i_ce)
		begin
			// Released line floats to its pull-up
			miso_q <= {miso_q[0], spi.miso | spi.miso_oe_b};
			if (i_rd)
				o_rdata <= rdmux;
			if (i_wr && i_addr == HR_ADDR)
				adr_q <= i_wdata;
			if (i_wr && i_addr == HR_LEN)
				len_q <= i_wdata[3:0];
			if (i_wr && i_addr == HR_TXD)
				txd_q <= i_wdata;
			// Set wins over clear on both flags
			txf_q <= (i_wr && i_addr == HR_TXD) | (txf_q & ~take_tx);
			rxf_q <= rx_set | (rxf_q & ~(i_rd && i_addr == HR_RXD));
			// Byte is complete at the last rise; no extra shift at the fall
			if (rx_set)
				rxd_q <= rx_q;
		end
	end
	// ----------------------------------------------------------------
	// Link sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_q   <= HS_IDLE;
			cmd_q  <= 8'h00;
			left_q <= 4'h0;
			ph_q   <= 2'h0;
			sh_q   <= 8'h00;
			rx_q   <= 8'h00;
			bc_q   <= 3'h0;
			div_q  <= 4'h0;
			sck_q  <= 1'b0;
			cs_b_q <= 1'b1;
		end
		else if (i_ce)
		begin
			case (st_q)
				HS_IDLE:
					if (go)
					begin
						// software issues enable and unlock first
						cmd_q  <= i_wdata;
						left_q <= len_go;
						ph_q   <= 2'h0;
						st_q   <= HS_LOAD;
					end
				HS_LOAD:
					if (ph_q != 2'h2 || data_ok)
					begin
						cs_b_q <= 1'b0;
						sh_q   <= (ph_q == 2'h0) ? cmd_q : (ph_q == 2'h1) ? adr_out :
						          rd_cmd ? 8'h00 : txd_q;
						bc_q   <= 3'h0;
						div_q  <= 4'h0;
						st_q   <= HS_SHIFT;
					end
				HS_SHIFT:
				begin
					div_q <= half ? 4'h0 : 4'(div_q + 4'h1);
					if (half && !sck_q)
					begin
						sck_q <= 1'b1;
						rx_q  <= rx_byte;
					end
					else if (half)
					begin
						sck_q <= 1'b0;
						sh_q  <= {sh_q[6:0], 1'b0};
						bc_q  <= 3'(bc_q + 3'h1);
						if (bc_q == 3'h7)
						begin
							st_q <= HS_LOAD;
							if (ph_q == 2'h0)
								ph_q <= has_addr ? 2'h1 : 2'h2;
							else
								ph_q <= 2'h2;
							if (ph_q == 2'h2)
								left_q <= 4'(left_q - 4'h1);
							if ((ph_q == 2'h2 && left_q == 4'h1) ||
							    (ph_q == 2'h1 && left_q == 4'h0) ||
							    (ph_q == 2'h0 && !has_addr && left_q == 4'h0))
								st_q <= HS_END;
						end
					end
				end
				HS_END:
				begin
					div_q <= half ? 4'h0 : 4'(div_q + 4'h1);
					if (half)
					begin
						cs_b_q <= 1'b1;
						st_q   <= HS_IDLE;
					end
				end
				default:
					st_q <= HS_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- rtc_link_props.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_link_props
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe_b,
	input wire logic i_main_above_trip,
	input wire logic i_main_above_backup,
	input wire logic i_alarm,
	input wire logic o_on_backup,
	input wire logic o_mfp_oe_b
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// ----------------------------------------------------------------
	// Supply gating
	// ----------------------------------------------------------------
	a_miso_backup: assert property (o_on_backup |-> miso_oe_b)
		else $error("miso driven on backup");
	// Synchronisers add latency, so the supply level must persist
	a_backup_entry: assert property ((!i_main_above_trip && !i_main_above_backup) [*6] |-> o_on_backup)
		else $error("backup not entered");
	a_backup_exit: assert property (i_main_above_trip [*6] |-> !o_on_backup)
		else $error("backup not left");
	a_pin_backup: assert property ((o_on_backup && !i_alarm) [*4] |-> o_mfp_oe_b)
		else $error("pin driven on backup without alarm");
	// ----------------------------------------------------------------
	// Link framing
	// ----------------------------------------------------------------
	// Chip-select passes a synchroniser, so release lags the frame end by three cycles
	a_miso_frame: assert property (cs_b [*4] |-> miso_oe_b)
		else $error("miso driven outside frame");
	a_sck_framed: assert property (sck |-> !cs_b)
		else $error("sck high outside frame");
	a_sck_high: assert property ($rose(sck) |-> sck [*8])
		else $error("sck high phase short");
	a_sck_low: assert property ($fell(sck) |-> !sck [*8])
		else $error("sck low phase short");
	a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while sck high");
	a_miso_hold: assert property (!miso_oe_b && !$past(miso_oe_b) && sck && $past(sck) |-> $stable(miso))
		else $error("miso moved while sck high");
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import rtc_pkg::*;
	logic       i_clk, i_rst_b, osc, oc, trip, bkup, alarm, wr, rd, psck, pcs;
	logic       mfp_oe_b, on_backup, minute;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, first, d;
	logic [7:0] got [16];
	logic [7:0] rc [3] = '{8'h03, 8'h01, 8'h02};
	int         pe [3] = '{4, 32, 16};
	int         err_total, n_tests, nb, nbits, cyc, k;
	rtc_spi_if spi();
	rtc_host u_rtc_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .spi(spi));
	rtc_dev #(.P_UID48(1'b1)) u_rtc_dev (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
		.i_osc(osc), .i_main_above_trip(trip), .i_main_above_backup(bkup), .i_alarm(alarm),
		.spi(spi), .o_mfp_oe_b(mfp_oe_b), .o_on_backup(on_backup), .o_minute(minute));
	rtc_link_props u_rtc_link_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .sck(spi.sck),
		.cs_b(spi.cs_b), .mosi(spi.mosi), .miso(spi.miso), .miso_oe_b(spi.miso_oe_b),
		.i_main_above_trip(trip), .i_main_above_backup(bkup), .i_alarm(alarm),
		.o_on_backup(on_backup), .o_mfp_oe_b(mfp_oe_b));
	// ----------------------------------------------------------------
	// Clock, oscillator, link monitor, timeout
	// ----------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Oscillator period of four clocks keeps the synchroniser margin
	always @(posedge i_clk)
	begin
		oc <= ~oc;
		if (oc)
			osc <= ~osc;
		psck <= spi.sck;
		pcs <= spi.cs_b;
		if (spi.cs_b)
			nb <= 0;
		else if (spi.sck && !psck)
			nb <= nb + 1;
		if (!spi.cs_b && spi.sck && !psck && nb < 8)
			first <= {first[6:0], spi.mosi};
		if (spi.cs_b && !pcs)
			nbits <= nb;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_total++;
			$display("unexpected at %0t: timeout", $time);
			finish_test;
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask
	task hw(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask
	task hr(input logic [2:0] a);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task poll(input int b, input logic v);
		int j;
		for (j = 0; j < 600; j++)
		begin
			hr(HR_STAT);
			if (d[b] === v)
				break;
		end
		chkb(d[b], v);
	endtask
	// Writes carry one data byte; reads fill got[] in order
	task xfer(input logic [7:0] c, input logic [7:0] a, input int n, input logic [7:0] v);
		int j;
		hw(HR_ADDR, a);
		hw(HR_LEN, 8'(n));
		if (c == C_WRITE || c == C_UNIQUE_ID_WRITE_COMMAND || c == C_UNLOCK)
			hw(HR_TXD, v);
		hw(HR_CMD, c);
		if (c == C_READ || c == C_UNIQUE_ID_READ_COMMAND)
			for (j = 0; j < n; j++)
			begin
				poll(1, 1'b1);
				hr(HR_RXD);
				got[j] = d;
			end
		poll(0, 1'b0);
		chk(first, c);
		chk(8'(nbits), 8'(8 * (n + ((c == C_WREN || c == C_UNLOCK) ? 1 : 2))));
	endtask
	task period(input int e);
		int t;
		logic p;
		repeat (2)
		begin
			p = mfp_oe_b;
			for (t = 0; t < 100; t++)
			begin
				@(posedge i_clk);
				#1;
				if (mfp_oe_b && !p)
					break;
				p = mfp_oe_b;
			end
		end
		chk(8'(t + 1), 8'(e));
	endtask
	task finish_test;
		$display("mismatches %0d of %0d comparisons", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{i_rst_b, osc, oc, alarm, wr, rd, psck, addr, wdata, first} = '0;
		{trip, bkup, pcs} = 3'h7;
		{err_total, n_tests, nb, nbits, cyc} = '0;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		xfer(C_READ, A_OUTCTL, 1, 8'h00);
		chk(got[0], OUTCTL_RST);
		chkb(mfp_oe_b, 1'b1);
		xfer(C_READ, A_TRIM, 1, 8'h00);
		chk(got[0], TRIM_RST);
		xfer(C_WRITE, A_TRIM, 1, 8'hA5);
		xfer(C_READ, A_TRIM, 1, 8'h00);
		chk(got[0], 8'hA5);
		xfer(C_WRITE, A_TKCTL, 1, 8'h80);
		xfer(C_READ, A_TKCTL, 1, 8'h00);
		chkb(got[0][B_TRIM_SIGN], 1'b1);
		// Write without enable must leave the blank byte alone
		xfer(C_UNIQUE_ID_WRITE_COMMAND, 8'h0F, 1, 8'h12);
		xfer(C_UNIQUE_ID_READ_COMMAND, 8'h0F, 3, 8'h00);
		for (k = 0; k < 3; k++)
			chk(got[k], ID_BLANK);
		// Enable and unlock first, then the ID write must land
		xfer(C_WREN, 8'h00, 0, 8'h00);
		xfer(C_UNLOCK, 8'h00, 1, UNLOCK_KEY);
		xfer(C_UNIQUE_ID_WRITE_COMMAND, 8'h0F, 1, 8'h12);
		xfer(C_UNIQUE_ID_READ_COMMAND, 8'h0F, 1, 8'h00);
		chk(got[0], 8'h12);
		xfer(C_WRITE, A_OUTCTL, 1, 8'h00);
		repeat (6) @(posedge i_clk);
		chkb(mfp_oe_b, 1'b0);
		// Nonzero trim stays in place while rates are measured
		for (k = 0; k < 3; k++)
		begin
			xfer(C_WRITE, A_OUTCTL, 1, 8'h40 | rc[k]);
			period(pe[k]);
		end
		xfer(C_WRITE, A_OUTCTL, 1, 8'h53);
		trip <= 1'b0;
		bkup <= 1'b0;
		repeat (10) @(posedge i_clk);
		chkb(on_backup, 1'b1);
		chkb(mfp_oe_b, 1'b1);
		alarm <= 1'b1;
		repeat (4) @(posedge i_clk);
		chkb(mfp_oe_b, 1'b0);
		alarm <= 1'b0;
		xfer(C_READ, A_TRIM, 1, 8'h00);
		chk(got[0], 8'hFF);
		trip <= 1'b1;
		repeat (10) @(posedge i_clk);
		chkb(on_backup, 1'b0);
		xfer(C_READ, A_TRIM, 1, 8'h00);
		chk(got[0], 8'hA5);
		finish_test;
	end
endmodule
`default_nettype wire
